// File: src/utc_pkg.sv
// package for the transmit-command byte decoder: codes, payload values, widths
// assumes both ends and the interface import it
package utc_pkg;
    localparam int          DATA_W        = 8;       // data bus width
    localparam logic [1:0]  CODE_IDLE     = 2'h0;    // idle command code
    localparam logic [1:0]  CODE_TX       = 2'h1;    // packet transmit code
    localparam logic [1:0]  CODE_WRITE    = 2'h2;    // register write code
    localparam logic [1:0]  CODE_READ     = 2'h3;    // register read code
    localparam logic [5:0]  PAY_EXT       = 6'h2F;   // extended address payload
    localparam logic [5:0]  PAY_TRANSMIT_WITHOUT_IDENTIFIER     = 6'h00;   // transmit without identifier
    localparam logic [1:0]  PAY_PID_HI    = 2'h0;    // upper payload bits of a pid transmit
    localparam logic [7:0]  IDLE_BYTE     = 8'h00;   // idle no-operation byte
    localparam int          CODE_MSB      = 7;       // command code position
    localparam int          CODE_LSB      = 6;

    // kind of operation decoded
    typedef enum logic [2:0] {
        UTC_OP_NONE    = 3'h0,
        UTC_OP_PID     = 3'h1,
        UTC_OP_TRANSMIT_WITHOUT_IDENTIFIER   = 3'h2,
        UTC_OP_WRITE   = 3'h3,
        UTC_OP_READ    = 3'h4,
        UTC_OP_BADTX   = 3'h5
    } utc_op_e;

    // command code of a byte
    function automatic logic [1:0] utc_code(input logic [7:0] b);
        utc_code = b[CODE_MSB:CODE_LSB];
    endfunction

    // payload of a byte
    function automatic logic [5:0] utc_payload(input logic [7:0] b);
        utc_payload = b[5:0];
    endfunction
endpackage

// File: src/utc_if.sv
// interface joining link and transceiver command path
// assumes one clock shared by both ends
`timescale 1ns/10ps
interface utc_if;
    import utc_pkg::*;
    logic [DATA_W-1:0] data;   // byte driven by the link
    logic              nxt;    // transceiver accepts current byte
    modport dev  (input data, output nxt);
    modport link (output data, input nxt);
endinterface

// File: src/utc_link.sv
// link end: issues commands on the data bus, holds each byte until accepted
// assumes the device end answers with nxt on the same clock
`timescale 1ns/10ps
module utc_link (
    input  wire logic                    clk_in,       // interface clock
    input  wire logic                    rst_b_in,     // sync reset, low
    utc_if.link                          bus,          // link side of bus
    input  wire logic                    req_in,       // start a command
    input  wire logic [utc_pkg::DATA_W-1:0] cmd_in,    // command byte
    input  wire logic                    has_next_in,  // a second byte follows
    input  wire logic [utc_pkg::DATA_W-1:0] next_in,   // second byte
    output logic                         busy_out,     // command in flight
    output logic                         done_out      // one-cycle, all accepted
);
    import utc_pkg::*;

    typedef enum logic [1:0] {UTC_L_IDLE = 2'h0, UTC_L_CMD = 2'h1, UTC_L_NEXT = 2'h3} utc_lst_e;

    typedef struct packed {
        utc_lst_e          st;     // sequence state
        logic [7:0]        data;   // driven byte
        logic [7:0]        nbyte;  // held second byte
        logic              more;   // second byte pending
        logic              busy;
        logic              done;
    } utc_link_s;

    utc_link_s r;       // registered state
    utc_link_s next_r;  // next state

    assign bus.data = r.data;
    assign busy_out = r.busy;
    assign done_out = r.done;

    // next-state logic
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        case (r.st)
            UTC_L_IDLE: begin
                next_r.data = IDLE_BYTE;            // default idle byte [RQ7]
                if (req_in) begin
                    next_r.st    = UTC_L_CMD;
                    next_r.data  = cmd_in;
                    next_r.nbyte = next_in;
                    next_r.more  = has_next_in;
                    next_r.busy  = 1'b1;
                end
            end
            UTC_L_CMD: begin
                if (bus.nxt) begin                  // held until taken [RQ9]
                    if (r.more) begin               // extended address or data follows [RQ2] [RQ4]
                        next_r.st   = UTC_L_NEXT;
                        next_r.data = r.nbyte;
                    end else begin
                        next_r.st   = UTC_L_IDLE;
                        next_r.data = IDLE_BYTE;    // [RQ7]
                        next_r.busy = 1'b0;
                        next_r.done = 1'b1;
                    end
                end
            end
            UTC_L_NEXT: begin
                if (bus.nxt) begin                  // [RQ9]
                    next_r.st   = UTC_L_IDLE;
                    next_r.data = IDLE_BYTE;        // [RQ7]
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                end
            end
            default: begin
                next_r.st = UTC_L_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            r <= '{st: UTC_L_IDLE, data: IDLE_BYTE, nbyte: 8'h00, more: 1'b0, busy: 1'b0, done: 1'b0};
        end else begin
            r <= next_r;
        end
    end
endmodule

// File: src/utc_dev.sv
// device end: decodes transmit-command bytes from the link
// assumes the link holds each byte until nxt is seen
// Summary of operation
// RQ1: pid transmit uses low four data bits
// RQ2: write payload 101111 takes following address byte
// RQ3: other write payload is six-bit address
// RQ4: read payload 101111 takes following address byte
// RQ5: other read payload is six-bit address
// RQ6: top two bits pick command type
// RQ7: link drives zero byte when idle
// RQ8: no-pid transmit starts after next byte
// RQ9: nxt accepts each byte; link holds it
`timescale 1ns/10ps
module utc_dev (
    input  wire logic        clk_in,        // interface clock
    input  wire logic        rst_b_in,      // sync reset, low
    utc_if.dev               bus,           // device side of bus
    input  wire logic        hold_in,       // device not ready to accept
    output utc_pkg::utc_op_e op_out,        // decoded operation
    output logic             op_valid_out,  // one-cycle, op fields valid
    output logic [3:0]       pid_out,       // packet identifier
    output logic [7:0]       addr_out,      // register address
    output logic             ext_out,       // address was extended
    output logic             tx_start_out   // one-cycle, transmission begins
);
    import utc_pkg::*;

    typedef enum logic [1:0] {UTC_D_IDLE = 2'h0, UTC_D_ADDR = 2'h1, UTC_D_DATA = 2'h3} utc_dst_e;

    typedef struct packed {
        utc_dst_e   st;      // decode state
        logic       rd;      // pending extended op is read
        logic       nxt;     // acceptance strobe
        utc_op_e    op;
        logic       vld;
        logic [3:0] pid;
        logic [7:0] addr;
        logic       ext;
        logic       txs;
    } utc_dev_s;

    utc_dev_s r;       // registered state
    utc_dev_s next_r;  // next state
    logic     take;    // byte accepted this cycle

    assign bus.nxt      = r.nxt;
    assign op_out       = r.op;
    assign op_valid_out = r.vld;
    assign pid_out      = r.pid;
    assign addr_out     = r.addr;
    assign ext_out      = r.ext;
    assign tx_start_out = r.txs;

    // nxt asserted for exactly the cycle a byte is taken
    always_comb begin
        take = r.nxt;
    end

    // decode and sequencing
    always_comb begin
        next_r     = r;
        next_r.vld = 1'b0;
        next_r.txs = 1'b0;
        next_r.nxt = 1'b0;
        case (r.st)
            UTC_D_IDLE: begin
                if (!take && !hold_in && utc_code(bus.data) != CODE_IDLE) begin   // idle byte ignored [RQ6]
                    next_r.nxt = 1'b1;                                           // accept command [RQ9]
                    next_r.ext = 1'b0;
                    case (utc_code(bus.data))                                     // [RQ6]
                        CODE_TX: begin
                            if (utc_payload(bus.data) == PAY_TRANSMIT_WITHOUT_IDENTIFIER) begin
                                next_r.st = UTC_D_DATA;                           // wait first data [RQ8]
                                next_r.op = UTC_OP_TRANSMIT_WITHOUT_IDENTIFIER;
                                next_r.vld = 1'b1;
                            end else if (bus.data[5:4] == PAY_PID_HI) begin
                                next_r.op  = UTC_OP_PID;
                                next_r.pid = bus.data[3:0];                       // [RQ1]
                                next_r.vld = 1'b1;
                                next_r.txs = 1'b1;
                            end else begin
                                next_r.op  = UTC_OP_BADTX;                        // undefined payload
                                next_r.vld = 1'b1;
                            end
                        end
                        CODE_WRITE, CODE_READ: begin
                            next_r.rd = (utc_code(bus.data) == CODE_READ);
                            if (utc_payload(bus.data) == PAY_EXT) begin
                                next_r.st = UTC_D_ADDR;                           // [RQ2] [RQ4]
                            end else begin
                                next_r.addr = {2'h0, utc_payload(bus.data)};      // [RQ3] [RQ5]
                                next_r.op   = (utc_code(bus.data) == CODE_READ) ? UTC_OP_READ : UTC_OP_WRITE;
                                next_r.vld  = 1'b1;
                            end
                        end
                        default: begin
                            next_r.op = UTC_OP_NONE;
                        end
                    endcase
                end
            end
            UTC_D_ADDR: begin
                if (!take && !hold_in) begin
                    next_r.nxt  = 1'b1;                          // accept address byte [RQ9]
                    next_r.addr = bus.data;                      // full address [RQ2] [RQ4]
                    next_r.ext  = 1'b1;
                    next_r.op   = r.rd ? UTC_OP_READ : UTC_OP_WRITE;
                    next_r.vld  = 1'b1;
                    next_r.st   = UTC_D_IDLE;
                end
            end
            UTC_D_DATA: begin
                if (!take && !hold_in) begin
                    next_r.nxt = 1'b1;                           // [RQ9]
                    next_r.txs = 1'b1;                           // start only now [RQ8]
                    next_r.st  = UTC_D_IDLE;
                end
            end
            default: begin
                next_r.st = UTC_D_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            r <= '{st: UTC_D_IDLE, rd: 1'b0, nxt: 1'b0, op: UTC_OP_NONE, vld: 1'b0,
                   pid: 4'h0, addr: 8'h00, ext: 1'b0, txs: 1'b0};
        end else begin
            r <= next_r;
        end
    end
endmodule

// File: tb/utc_assertions.sv
// checker for the command byte wire between link and device ends
// assumes one clock; instantiated by tb beside the interface
`timescale 1ns/10ps
module utc_assertions (
    input wire logic                        clk_in,   // interface clock
    input wire logic                        rst_b_in, // sync reset, low
    input wire logic [utc_pkg::DATA_W-1:0]  data,     // byte from link
    input wire logic                        nxt       // accept pulse
);
    import utc_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    // extended form of a register command
    wire ext_cmd = data[7] && (data[5:0] == PAY_EXT);
    wire transmit_without_identifier   = (data == {CODE_TX, PAY_TRANSMIT_WITHOUT_IDENTIFIER});
    a_reset_quiet: assert property ($past(!rst_b_in) |-> data == IDLE_BYTE && !nxt)
        else $error("bus not quiet after reset");
    a_nxt_single: assert property (nxt |=> !nxt)
        else $error("accept pulse too long");
    a_data_held: assert property (data != IDLE_BYTE && !nxt |=> $stable(data))
        else $error("byte changed before accept");
    a_held_at_accept: assert property (nxt |-> $stable(data))
        else $error("byte changed during accept");
    a_ext_follows: assert property (nxt && ext_cmd |=> !nxt ##1 nxt)
        else $error("no address byte after extended command");
    a_transmit_without_identifier_more: assert property (nxt && transmit_without_identifier |=> data != IDLE_BYTE)
        else $error("no data byte after transmit without identifier");
    a_last_idle: assert property (nxt && !ext_cmd && !transmit_without_identifier |=> data == IDLE_BYTE)
        else $error("bus not idle after last byte");
    c_ext: cover property (nxt && ext_cmd);
endmodule

// File: tb/tb.sv
// self-checking bench: link and device ends joined by the interface
// assumes inputs change at falling edges, outputs read there too
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin n_mismatch++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb;
    import utc_pkg::*;
    logic       clk_in = 0;    // 200 MHz clock
    logic       rst_b_in = 0;  // reset, low
    logic       req = 0;       // link start
    logic [7:0] cmd = 0;       // command byte
    logic       has = 0;       // second byte follows
    logic [7:0] nb = 0;        // second byte
    logic       hold = 0;      // device stall
    logic       busy, done, vld, txs, ext;
    utc_op_e    op;
    logic [3:0] pid;
    logic [7:0] addr;
    utc_op_e    g_op;          // captured decode
    logic [7:0] g_addr;
    logic [3:0] g_pid;
    logic       g_ext, dn;
    int         c_vld, c_txs, n_txs, i, cyc, n_mismatch = 0, num_checks = 0;
    utc_if u_bus();
    utc_link i_utc_link (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus(u_bus), .req_in(req), .cmd_in(cmd),
        .has_next_in(has), .next_in(nb), .busy_out(busy), .done_out(done));
    utc_dev i_utc_dev (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus(u_bus), .hold_in(hold), .op_out(op),
        .op_valid_out(vld), .pid_out(pid), .addr_out(addr), .ext_out(ext), .tx_start_out(txs));
    utc_assertions i_utc_assertions (.clk_in(clk_in), .rst_b_in(rst_b_in), .data(u_bus.data),
        .nxt(u_bus.nxt));
    // clock and hang guard
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // record decode pulses until the link reports done
    task automatic wait_done();
        dn = 0; n_txs = 0; c_vld = -1;
        for (i = 0; i < 30 && !dn; i++) begin
            @(negedge clk_in);
            if (vld === 1'b1) begin
                c_vld = i; g_op = op; g_pid = pid; g_addr = addr; g_ext = ext;
            end
            if (txs === 1'b1) begin
                c_txs = i; n_txs++;
            end
            if (done === 1'b1) dn = 1;
        end
        `CHK("done", 1'b1, dn)
        `CHK("idle byte", IDLE_BYTE, u_bus.data)
    endtask
    task automatic issue(input logic [7:0] c, input logic h, input logic [7:0] n);
        @(negedge clk_in);
        req = 1; cmd = c; has = h; nb = n;
        @(negedge clk_in);
        req = 0;
        wait_done();
    endtask
    task automatic t_idle();
        repeat (8) @(negedge clk_in) `CHK("idle nxt", 1'b0, u_bus.nxt)
    endtask
    task automatic t_pid();
        int p;
        for (p = 1; p < 16; p++) begin
            issue({CODE_TX, PAY_PID_HI, p[3:0]}, 0, 8'h00);
            `CHK("pid op", UTC_OP_PID, g_op)
            `CHK("pid", p[3:0], g_pid)
            `CHK("pid start", c_vld, c_txs)
        end
    endtask
    task automatic t_transmit_without_identifier();
        issue(8'h40, 1, 8'h5A);
        `CHK("transmit_without_identifier op", UTC_OP_TRANSMIT_WITHOUT_IDENTIFIER, g_op)
        `CHK("transmit_without_identifier starts", 1, n_txs)
        `CHK("transmit_without_identifier delay", c_vld + 2, c_txs)
        issue(8'h55, 0, 8'h00);
        `CHK("bad tx op", UTC_OP_BADTX, g_op)
    endtask
    task automatic t_reg();
        logic [7:0] cs [4] = '{8'h9A, 8'hAF, 8'hD5, 8'hEF};
        logic [7:0] ns [4] = '{8'h00, 8'h8C, 8'h00, 8'hC7};
        logic [7:0] ea [4] = '{8'h1A, 8'h8C, 8'h15, 8'hC7};
        int k;
        for (k = 0; k < 4; k++) begin
            issue(cs[k], k[0], ns[k]);
            `CHK("reg op", k < 2 ? UTC_OP_WRITE : UTC_OP_READ, g_op)
            `CHK("reg addr", ea[k], g_addr)
            `CHK("reg ext", k[0], g_ext)
            `CHK("reg decoded", 1'b1, (c_vld >= 0))
            `CHK("reg no start", 0, n_txs)
        end
    endtask
    task automatic t_hold();
        @(negedge clk_in);
        hold = 1; req = 1; cmd = 8'hC1; has = 0;
        @(negedge clk_in);
        req = 0;
        repeat (6) @(negedge clk_in) `CHK("stall nxt", 1'b0, u_bus.nxt)
        `CHK("held byte", 8'hC1, u_bus.data)
        hold = 0;
        wait_done();
        `CHK("stall addr", 8'h01, g_addr)
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        rst_b_in = 1;
        t_idle();
        t_pid();
        t_transmit_without_identifier();
        t_reg();
        t_hold();
        end_of_test();
    end
endmodule
